// file: rtl/pin_mux_pkg.sv
// Purpose: constants for the pin-function multiplexer.
// Assumes: Avalon-MM word addressing, one 8-bit register per word.
// Notes: ports B to D hold their selections only; port A is decoded.
// Function
// R1: bits 5:4 set port D drive level.
// R2: bits 1:0 set port C drive level.
// R3: drive register bits 7:6 read zero.
// R4: bits 3:2 set middle group drive level.
// R5: PA3 picks I/O, serial in, comparator, LCD.
// R6: PA2 picks I/O with irq one, or LCD.
// R7: PA1 picks I/O irq zero, serial out, LCD.
// R8: PA0 picks I/O capture, capture only, LCD.
// R9: PA7 picks capture I/O, timer out, LCD, analog.
// R10: PA6 picks clock I/O, LCD, analog, reference out.
// R11: PA5 picks I/O, LCD, analog, reference in.
// R12: PA4 picks clock I/O, LCD, analog.
// R13: Software selects pin before enabling peripheral.
// R14: Software sets direction input for shared inputs.
// R15: Software disables peripheral before changing selection.
// R16: Input route register bits 5:0, 7:6 zero.
// R17: Direction one is input, zero drives output.
// R18: Selected function drives the pin, not latch.
package pin_mux_pkg;
	localparam int REG_COUNT = 11;
	localparam logic [3:0] IDX_DRIVE = 4'h0;
	localparam logic [3:0] IDX_PA_LO = 4'h1;
	localparam logic [3:0] IDX_PA_HI = 4'h2;
	localparam logic [3:0] IDX_ROUTE = 4'h8;
	localparam logic [3:0] IDX_PA_DIR = 4'h9;
	localparam logic [3:0] IDX_PA_DATA = 4'hA;
	localparam logic [3:0] IDX_PA_PIN = 4'hB;
	localparam logic [7:0] REG_WMASK [0:REG_COUNT-1] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h3F,
		8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
	localparam logic [7:0] REG_RESET [0:REG_COUNT-1] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
	localparam int PC_FIELD_LSB = 0;
	localparam int MID_FIELD_LSB = 2;
	localparam int PD_FIELD_LSB = 4;
	localparam logic [1:0] SEL_00 = 2'h0;
	localparam logic [1:0] SEL_01 = 2'h1;
	localparam logic [1:0] SEL_10 = 2'h2;
	localparam logic [1:0] SEL_11 = 2'h3;
	typedef enum logic [1:0] {BUS_IDLE = 2'h1, BUS_ACK = 2'h2} bus_state_e;
	typedef enum logic [2:0] {
		KIND_GPIO = 3'h0,
		KIND_DRV = 3'h1,
		KIND_PIN_IN = 3'h2,
		KIND_LCD = 3'h3,
		KIND_ANALOG = 3'h4,
		KIND_REF_OUT = 3'h5,
		KIND_REF_IN = 3'h6
	} pin_kind_e;
	localparam pin_kind_e PIN_KIND [0:7][0:3] = '{
		'{KIND_GPIO, KIND_GPIO, KIND_PIN_IN, KIND_LCD},
		'{KIND_GPIO, KIND_GPIO, KIND_DRV, KIND_LCD},
		'{KIND_GPIO, KIND_GPIO, KIND_GPIO, KIND_LCD},
		'{KIND_GPIO, KIND_PIN_IN, KIND_DRV, KIND_LCD},
		'{KIND_GPIO, KIND_GPIO, KIND_LCD, KIND_ANALOG},
		'{KIND_GPIO, KIND_LCD, KIND_ANALOG, KIND_REF_IN},
		'{KIND_GPIO, KIND_LCD, KIND_ANALOG, KIND_REF_OUT},
		'{KIND_GPIO, KIND_DRV, KIND_LCD, KIND_ANALOG}};
endpackage : pin_mux_pkg

// file: rtl/pin_function_select_mux.sv
// Purpose: port A pin-function multiplexer, drive levels and input routing.
// Assumes: peripherals and pins are outside; pins arrive asynchronously.
// Notes: every access answers with exactly one cycle of waitrequest low.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pin_function_select_mux
	import pin_mux_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] pa_pin_in,
	input wire logic comparator_out,
	input wire logic serial_data_out,
	input wire logic periodic_timer_out,
	input wire logic [7:0] lcd_com_seg_drive,
	output logic [7:0] pa_pin_out,
	output logic [7:0] pa_pin_oe_n,
	output logic [7:0] pa_analog_sel,
	output logic reference_voltage_out_sel,
	output logic reference_voltage_in_sel,
	output logic [1:0] port_c_low_drive_field,
	output logic [1:0] port_mid_drive_field,
	output logic [1:0] port_d_drive_field,
	output logic irq_one_route,
	output logic irq_zero_route,
	output logic serial_in_route,
	output logic serial_clk_route,
	output logic chip_select_route,
	output logic receive_route,
	output logic ext_irq_one,
	output logic ext_irq_zero,
	output logic std_timer_capture_in,
	output logic periodic_timer_capture_in,
	output logic compact_timer_clk_in,
	output logic periodic_timer_clk_in,
	output logic serial_data_in
);
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	bus_state_e state_r, state_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] regs_r [0:REG_COUNT-1];
	logic [7:0] regs_nxt [0:REG_COUNT-1];
	logic [7:0] pin_clean_r;

	// Writes land at the edge where the master sees waitrequest low, so the
	// held address and data are used rather than a copy taken earlier.
	always_comb begin
		state_nxt = state_r;
		wait_nxt = 1'b1;
		rdata_nxt = rdata_r;
		regs_nxt = regs_r;
		case (state_r)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					state_nxt = BUS_ACK;
					wait_nxt = 1'b0;
					rdata_nxt = 32'h0;
					for (int i = 0; i < REG_COUNT; i++) begin
						if (avs_address == 4'(i)) begin
							rdata_nxt[7:0] = regs_r[i];
						end
					end
					if (avs_address == IDX_PA_PIN) begin
						rdata_nxt[7:0] = pin_clean_r; // R17
					end
				end
			end
			BUS_ACK: begin
				state_nxt = BUS_IDLE;
				for (int i = 0; i < REG_COUNT; i++) begin
					if (avs_write && avs_byteenable[0] && avs_address == 4'(i)) begin
						regs_nxt[i] = avs_writedata[7:0] & REG_WMASK[i]; // R3 R16
					end
				end
			end
			default: state_nxt = BUS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= BUS_IDLE;
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
			regs_r <= REG_RESET;
		end else begin
			state_r <= state_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			regs_r <= regs_nxt;
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	logic [7:0] sync1_r, sync2_r, sync3_r;
	logic [7:0] pin_clean_nxt;

	// A bit is accepted only when the last two stages agree, which filters
	// a single-cycle glitch at the cost of one extra cycle of latency.
	always_comb begin
		pin_clean_nxt = (~(sync2_r ^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & pin_clean_r);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
			sync3_r <= 8'h00;
			pin_clean_r <= 8'h00;
		end else begin
			sync1_r <= pa_pin_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			pin_clean_r <= pin_clean_nxt;
		end
	end

	// ----------------------------------------
	// Port A function decode
	// ----------------------------------------
	logic [15:0] sel_w;
	pin_kind_e kind_w [0:7];
	logic [7:0] periph_drive_w;
	logic [7:0] out_nxt, oe_n_nxt, analog_nxt;

	assign sel_w = {regs_r[IDX_PA_HI], regs_r[IDX_PA_LO]};
	assign periph_drive_w = {periodic_timer_out, 3'h0, comparator_out, 1'b0, serial_data_out, 1'b0};

	generate
		for (genvar p = 0; p < 8; p++) begin : g_pin
			assign kind_w[p] = PIN_KIND[p][sel_w[2*p +: 2]]; // R5 R6 R7 R8 R9 R10 R11 R12
			always_comb begin
				case (kind_w[p])
					KIND_GPIO: begin
						out_nxt[p] = regs_r[IDX_PA_DATA][p];
						oe_n_nxt[p] = regs_r[IDX_PA_DIR][p]; // R17
					end
					KIND_DRV: begin
						out_nxt[p] = periph_drive_w[p]; // R18
						oe_n_nxt[p] = 1'b0;
					end
					KIND_LCD: begin
						out_nxt[p] = lcd_com_seg_drive[p]; // R18
						oe_n_nxt[p] = 1'b0;
					end
					default: begin
						out_nxt[p] = 1'b0;
						oe_n_nxt[p] = 1'b1;
					end
				endcase
				analog_nxt[p] = kind_w[p] == KIND_ANALOG || kind_w[p] == KIND_REF_OUT ||
					kind_w[p] == KIND_REF_IN;
			end
		end
	endgenerate

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	logic [7:0] drive_w, route_w;
	logic [6:0] pin_in_nxt;

	assign drive_w = regs_r[IDX_DRIVE];
	assign route_w = regs_r[IDX_ROUTE];

	// Shared inputs follow the pin only while their function is selected;
	// otherwise the peripheral sees a quiet low.
	always_comb begin
		pin_in_nxt[0] = kind_w[2] == KIND_GPIO && pin_clean_r[2]; // R6
		pin_in_nxt[1] = kind_w[1] == KIND_GPIO && pin_clean_r[1]; // R7
		pin_in_nxt[2] = (kind_w[0] == KIND_GPIO || kind_w[0] == KIND_PIN_IN) && pin_clean_r[0]; // R8
		pin_in_nxt[3] = kind_w[7] == KIND_GPIO && pin_clean_r[7]; // R9
		pin_in_nxt[4] = kind_w[6] == KIND_GPIO && pin_clean_r[6]; // R10
		pin_in_nxt[5] = kind_w[4] == KIND_GPIO && pin_clean_r[4]; // R12
		pin_in_nxt[6] = kind_w[3] == KIND_PIN_IN && pin_clean_r[3]; // R5
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pa_pin_out <= 8'h00;
			pa_pin_oe_n <= 8'hFF;
			pa_analog_sel <= 8'h00;
			reference_voltage_out_sel <= 1'b0;
			reference_voltage_in_sel <= 1'b0;
			port_c_low_drive_field <= 2'h0;
			port_mid_drive_field <= 2'h0;
			port_d_drive_field <= 2'h0;
			{irq_one_route, irq_zero_route, serial_in_route} <= 3'h0;
			{serial_clk_route, chip_select_route, receive_route} <= 3'h0;
			{serial_data_in, compact_timer_clk_in, periodic_timer_clk_in} <= 3'h0;
			{periodic_timer_capture_in, std_timer_capture_in} <= 2'h0;
			{ext_irq_zero, ext_irq_one} <= 2'h0;
		end else begin
			pa_pin_out <= out_nxt;
			pa_pin_oe_n <= oe_n_nxt;
			pa_analog_sel <= analog_nxt;
			reference_voltage_out_sel <= kind_w[6] == KIND_REF_OUT; // R10
			reference_voltage_in_sel <= kind_w[5] == KIND_REF_IN; // R11
			port_c_low_drive_field <= drive_w[PC_FIELD_LSB +: 2]; // R2
			port_mid_drive_field <= drive_w[MID_FIELD_LSB +: 2]; // R4
			port_d_drive_field <= drive_w[PD_FIELD_LSB +: 2]; // R1
			{irq_one_route, irq_zero_route, serial_in_route} <= route_w[5:3]; // R16
			{serial_clk_route, chip_select_route, receive_route} <= route_w[2:0]; // R16
			ext_irq_one <= pin_in_nxt[0];
			ext_irq_zero <= pin_in_nxt[1];
			std_timer_capture_in <= pin_in_nxt[2];
			periodic_timer_capture_in <= pin_in_nxt[3];
			compact_timer_clk_in <= pin_in_nxt[4];
			periodic_timer_clk_in <= pin_in_nxt[5];
			serial_data_in <= pin_in_nxt[6];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_pd_drive_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
		(state_r == BUS_ACK && avs_write && avs_byteenable[0] && avs_address == IDX_DRIVE)
		|-> ##2 port_d_drive_field == $past(avs_writedata[5:4], 2))
		else $error("port D drive level does not follow the write");
	chk_pc_drive_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
		(state_r == BUS_ACK && avs_write && avs_byteenable[0] && avs_address == IDX_DRIVE)
		|=> ##1 port_c_low_drive_field == $past(avs_writedata[1:0], 2))
		else $error("port C drive level does not follow the write");
	chk_drive_top_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
		(state_r == BUS_IDLE && avs_read && avs_address == IDX_DRIVE)
		|=> !avs_waitrequest && avs_readdata[7:6] == 2'h0)
		else $error("unimplemented drive bits read nonzero");
	chk_bus_one_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_r == BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest low not exactly one cycle");
	chk_pa3_comparator: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
		sel_w[7:6] == SEL_10 |=> pa_pin_out[3] == $past(comparator_out) && !pa_pin_oe_n[3])
		else $error("PA3 does not carry the comparator output");
	chk_pa2_irq_one: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
		sel_w[5:4] != SEL_11 |=> ext_irq_one == $past(pin_clean_r[2]))
		else $error("irq one does not follow PA2");
	chk_pa1_serial_out: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
		sel_w[3:2] == SEL_10 |=> pa_pin_out[1] == $past(serial_data_out) && !pa_pin_oe_n[1])
		else $error("PA1 does not carry serial data out");
	chk_pa7_analog: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
		sel_w[15:14] == SEL_11 |=> pa_analog_sel[7] && pa_pin_oe_n[7])
		else $error("PA7 analog select not applied");
	chk_route_follow: assert property (@(posedge sys_clk) disable iff (!reset_n) // R16
		$changed(route_w) |=> irq_one_route == $past(route_w[5]) && receive_route == $past(route_w[0]))
		else $error("input routing outputs stale");
	chk_dir_input: assert property (@(posedge sys_clk) disable iff (!reset_n) // R17
		(kind_w[5] == KIND_GPIO && regs_r[IDX_PA_DIR][5]) |=> pa_pin_oe_n[5])
		else $error("PA5 driven while set as input");
	chk_mid_drive_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
		(state_r == BUS_ACK && avs_write && avs_byteenable[0] && avs_address == IDX_DRIVE)
		|-> ##2 port_mid_drive_field == $past(avs_writedata[3:2], 2))
		else $error("middle group drive level does not follow the write");
	chk_pa3_serial_in: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
		sel_w[7:6] == SEL_01 |=> serial_data_in == $past(pin_clean_r[3]) && pa_pin_oe_n[3])
		else $error("PA3 does not feed serial data in");
	chk_pa3_lcd: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
		sel_w[7:6] == SEL_11 |=> pa_pin_out[3] == $past(lcd_com_seg_drive[3]) && !pa_pin_oe_n[3])
		else $error("PA3 does not carry its LCD drive");
	chk_pa2_lcd: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
		sel_w[5:4] == SEL_11 |=> !ext_irq_one && !pa_pin_oe_n[2])
		else $error("PA2 LCD selection leaves irq one live");
	chk_pa1_irq_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
		(sel_w[3:2] == SEL_00 || sel_w[3:2] == SEL_01) |=> ext_irq_zero == $past(pin_clean_r[1]))
		else $error("irq zero does not follow PA1");
	chk_pa0_capture: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
		sel_w[1:0] != SEL_11 |=> std_timer_capture_in == $past(pin_clean_r[0]))
		else $error("capture input does not follow PA0");
	chk_pa0_capture_only: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
		sel_w[1:0] == SEL_10 |=> pa_pin_oe_n[0])
		else $error("PA0 driven while capture only");
	chk_pa7_timer_out: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
		sel_w[15:14] == SEL_01 |=> pa_pin_out[7] == $past(periodic_timer_out) && !pa_pin_oe_n[7])
		else $error("PA7 does not carry the timer output");
	chk_pa7_capture: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
		sel_w[15:14] == SEL_00 |=> periodic_timer_capture_in == $past(pin_clean_r[7]))
		else $error("timer capture input does not follow PA7");
	chk_pa6_clock_in: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
		sel_w[13:12] == SEL_00 |=> compact_timer_clk_in == $past(pin_clean_r[6]))
		else $error("compact timer clock does not follow PA6");
	chk_pa6_ref_out: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
		sel_w[13:12] == SEL_11 |=> reference_voltage_out_sel && pa_analog_sel[6])
		else $error("PA6 reference output not selected");
	chk_pa5_ref_in: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
		sel_w[11:10] == SEL_11 |=> reference_voltage_in_sel && pa_analog_sel[5] && pa_pin_oe_n[5])
		else $error("PA5 reference input not selected");
	chk_pa4_clock_in: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
		(sel_w[9:8] == SEL_00 || sel_w[9:8] == SEL_01) |=> periodic_timer_clk_in == $past(pin_clean_r[4]))
		else $error("timer clock input does not follow PA4");
	chk_pa4_lcd: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
		sel_w[9:8] == SEL_10 |=> !periodic_timer_clk_in && pa_pin_out[4] == $past(lcd_com_seg_drive[4]))
		else $error("PA4 does not carry its LCD drive");
endmodule : pin_function_select_mux
`default_nettype wire

// file: sim/pin_side_model.sv
// Purpose: far side of the pin mux: port A pins with pull-ups and peripheral outputs.
// Assumes: peripherals share sys_clk; nothing outside drives a pin.
// Notes: comparator, serial and timer outputs stay idle until the bench has set the pin selection; the LCD drive is fixed.
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
	input wire logic [7:0] pa_pin_out,
	input wire logic [7:0] pa_pin_oe_n,
	input wire logic [7:0] lcd_level,
	input wire logic [2:0] periph_level,
	output logic [7:0] pa_pin_in,
	output logic comparator_out,
	output logic serial_data_out,
	output logic periodic_timer_out,
	output logic [7:0] lcd_com_seg_drive
);
	// A released pin is pulled high, so a stale driven level can never read back.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pa_pin_in[i] = pa_pin_oe_n[i] ? 1'b1 : pa_pin_out[i];
		end
	end
	// The bench raises these only after selecting the pin and drops them first.
	assign comparator_out = periph_level[0];
	assign serial_data_out = periph_level[1];
	assign periodic_timer_out = periph_level[2];
	assign lcd_com_seg_drive = lcd_level;
endmodule : pin_side_model
`default_nettype wire

// file: sim/test_pin_function_select_mux.sv
// Purpose: self-checking bench for the pin-function multiplexer.
// Assumes: one register per word, one waitrequest-low cycle per access.
// Notes: expected pin sources come from a per-pin table of function kinds.
`timescale 1ns/1ps
`default_nettype none
module test_pin_function_select_mux;
	localparam logic [7:0] DIR_V = 8'h0F;
	localparam logic [7:0] LATCH_V = 8'hDA;
	localparam logic [7:0] LCD_V = 8'hA5;
	localparam logic [31:0] KINDS [0:7] = '{"GGIL", "GGSL", "GGGL", "GICL", "GGLA", "GLAA",
		"GLAA", "GPLA"};
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0;
	logic [2:0] periph = 3'h0;
	logic [31:0] avs_readdata;
	logic [7:0] pa_pin_in, lcd_com_seg_drive, pa_pin_out, pa_pin_oe_n, pa_analog_sel, q, lvl;
	logic [1:0] port_c_low_drive_field, port_mid_drive_field, port_d_drive_field;
	logic avs_waitrequest, comparator_out, serial_data_out, periodic_timer_out;
	logic reference_voltage_out_sel, reference_voltage_in_sel, irq_one_route, irq_zero_route;
	logic serial_in_route, serial_clk_route, chip_select_route, receive_route, ext_irq_one;
	logic ext_irq_zero, std_timer_capture_in, periodic_timer_capture_in, compact_timer_clk_in;
	logic periodic_timer_clk_in, serial_data_in;
	logic [2:0] e;
	int fail_count = 0;
	int comparisons = 0;
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	pin_function_select_mux pin_function_select_mux_i (.sys_clk, .reset_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.pa_pin_in, .comparator_out, .serial_data_out, .periodic_timer_out, .lcd_com_seg_drive,
		.pa_pin_out, .pa_pin_oe_n, .pa_analog_sel, .reference_voltage_out_sel,
		.reference_voltage_in_sel, .port_c_low_drive_field, .port_mid_drive_field,
		.port_d_drive_field, .irq_one_route, .irq_zero_route, .serial_in_route, .serial_clk_route,
		.chip_select_route, .receive_route, .ext_irq_one, .ext_irq_zero, .std_timer_capture_in,
		.periodic_timer_capture_in, .compact_timer_clk_in, .periodic_timer_clk_in, .serial_data_in);
	pin_side_model pin_side_model_i (.pa_pin_out, .pa_pin_oe_n, .lcd_level(LCD_V),
		.periph_level(periph), .pa_pin_in, .comparator_out, .serial_data_out,
		.periodic_timer_out, .lcd_com_seg_drive);
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic bus_op(input logic rd, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= rd;
		avs_write <= !rd;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			fail_count++;
			finish_test();
		end
	endtask : bus_op
	// Returns pin oe_n, driven level and analog select for a pin and its code.
	function automatic logic [2:0] exp_pin(input int n, input int c);
		logic [7:0] k;
		k = KINDS[n][31-8*c -: 8];
		case (k)
			"G": return {DIR_V[n], LATCH_V[n], 1'b0};
			"L": return {1'b0, LCD_V[n], 1'b0};
			"C": return {1'b0, periph[0], 1'b0};
			"S": return {1'b0, periph[1], 1'b0};
			"P": return {1'b0, periph[2], 1'b0};
			"A": return 3'h5;
			default: return 3'h4;
		endcase
	endfunction : exp_pin
	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 13; i++) begin
			bus_op(1'b1, 4'(i), 8'h00);
			if (i != 11) check(q, (i == 9) ? 8'hFF : 8'h00);
			bus_op(1'b0, 4'(i), 8'hFF);
			bus_op(1'b1, 4'(i), 8'h00);
			if (i != 11) check(q, (i == 12) ? 8'h00 : (i inside {0, 4, 6, 8}) ? 8'h3F : 8'hFF);
		end
		avs_byteenable <= 4'hE;
		bus_op(1'b0, 4'h1, 8'h00);
		avs_byteenable <= 4'hF;
		bus_op(1'b1, 4'h1, 8'h00);
		check(q, 8'hFF);
		bus_op(1'b0, 4'h8, 8'hEA);
		repeat (2) @(posedge sys_clk);
		check(8'({irq_one_route, irq_zero_route, serial_in_route, serial_clk_route,
			chip_select_route, receive_route}), 8'h2A);
		for (int k = 0; k < 2; k++) begin
			lvl = k ? 8'h24 : 8'hDB;
			bus_op(1'b0, 4'h0, lvl);
			repeat (2) @(posedge sys_clk);
			check(8'(port_d_drive_field), 8'(lvl[5:4]));
			check(8'(port_mid_drive_field), 8'(lvl[3:2]));
			check(8'(port_c_low_drive_field), 8'(lvl[1:0]));
		end
		bus_op(1'b0, 4'h9, DIR_V);
		bus_op(1'b0, 4'hA, LATCH_V);
		for (int c = 0; c < 4; c++) begin
			periph <= 3'h0;
			bus_op(1'b0, 4'h1, {4{2'(c)}});
			bus_op(1'b0, 4'h2, {4{2'(c)}});
			periph <= c[0] ? 3'h5 : 3'h3;
			repeat (8) @(posedge sys_clk);
			for (int n = 0; n < 8; n++) begin
				e = exp_pin(n, c);
				lvl[n] = e[2] | e[1];
				check(8'(pa_pin_oe_n[n]), 8'(e[2]));
				if (!e[2]) check(8'(pa_pin_out[n]), 8'(e[1]));
				check(8'(pa_analog_sel[n]), 8'(e[0]));
			end
			check(8'(std_timer_capture_in), 8'(lvl[0] && c != 3));
			check(8'(ext_irq_zero), 8'(lvl[1] && c < 2));
			check(8'(ext_irq_one), 8'(lvl[2] && c < 3));
			check(8'(serial_data_in), 8'(lvl[3] && c == 1));
			check(8'(periodic_timer_clk_in), 8'(lvl[4] && c < 2));
			check(8'(compact_timer_clk_in), 8'(lvl[6] && c == 0));
			check(8'(periodic_timer_capture_in), 8'(lvl[7] && c == 0));
			check(8'({reference_voltage_out_sel, reference_voltage_in_sel}), 8'(c == 3 ? 3 : 0));
			bus_op(1'b1, 4'hB, 8'h00);
			check(q, lvl);
		end
		finish_test();
	end
endmodule : test_pin_function_select_mux
`default_nettype wire
